// file: design/abh_cfg.svh
`ifndef ABH_CFG_SVH
`define ABH_CFG_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ABH_OFF_OPT1        8'h00
`define ABH_OFF_OPT2        8'h04
`define ABH_OFF_OPT3        8'h08
`define ABH_OFF_OPT4        8'h0C
`define ABH_OFF_OPT5        8'h10
`define ABH_OFF_HB_THR      8'h14
`define ABH_OFF_HB_HYS      8'h18
`define ABH_OFF_CFG         8'h1C
`define ABH_OFF_STATUS      8'h20
`define ABH_OFF_LATCH_CLR   8'h24
`define ABH_OFF_CT_NOW      8'h28

// ****************************************************************
// field positions
// ****************************************************************
`define ABH_OPT_LATCH       0
`define ABH_OPT_INERR       1
`define ABH_OPT_INVERT      2
`define ABH_OPT_HOLDRST     3
`define ABH_CFG_OUT1_LSB    0
`define ABH_CFG_OUT1_MSB    1
`define ABH_ST_ALM_LSB      0
`define ABH_ST_ALM_MSB      4
`define ABH_ST_DO_LSB       5
`define ABH_ST_DO_MSB       9
`define ABH_ST_HB_ALM       10
`define ABH_ST_HB_QUAL      11

// ****************************************************************
// reset values and limits
// ****************************************************************
`define ABH_OPT_RST         4'h0
`define ABH_AMP_RST         10'h000
`define ABH_AMP_MAX         10'h3E8
`define ABH_OUT1_RST        2'h0
`define ABH_OUT1_RELAY      2'h0
`define ABH_OUT1_SSR        2'h1
`define ABH_OUT1_CURRENT    2'h2
`define ABH_OUT1_VOLTAGE    2'h3

// ****************************************************************
// timing
// ****************************************************************
`define ABH_CLK_HZ          125000000
`define ABH_HB_ON_TIME_MS   300
`define ABH_HB_ON_CYCLES    (`ABH_HB_ON_TIME_MS * (`ABH_CLK_HZ / 1000))

`endif

// file: design/abh_pkg.sv
`default_nettype none

package abh_pkg;

	typedef logic [3:0] abh_opt_type;
	typedef logic [9:0] abh_amp_type;
	typedef logic [1:0] abh_out1_type;

	typedef enum logic [1:0] {
		HB_OFF,
		HB_WAIT,
		HB_OK,
		HB_BREAK
	} abh_hb_state_type;

endpackage : abh_pkg

`default_nettype wire

// file: design/abh_alarm_chan.sv
`timescale 1ns/1ns
`default_nettype none
`include "abh_cfg.svh"

module abh_alarm_chan (
	input  wire logic                 sys_clk_i,
	input  wire logic                 nrst_i,
	input  wire abh_pkg::abh_opt_type option_i,
	input  wire logic                 event_i,
	input  wire logic                 hold_type_i,
	input  wire logic                 input_error_i,
	input  wire logic                 rearm_i,
	input  wire logic                 latch_clr_i,
	output logic                      alarm_o,
	output logic                      do_o
);
	import abh_pkg::*;

	logic hold_r;
	logic latch_r;
	logic live;
	logic state;

	// ****************************************************************
	// hold suppression
	// ****************************************************************
	// armed by reset (power cycle); released once the event first clears
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hold_r <= 1'b1;
		end else if (rearm_i && option_i[`ABH_OPT_HOLDRST] && hold_type_i) begin
			hold_r <= 1'b1;
		end else if (!event_i) begin
			hold_r <= 1'b0;
		end
	end

	always_comb begin
		live = (event_i && !(hold_type_i && hold_r))
			|| (option_i[`ABH_OPT_INERR] && input_error_i);
	end

	// ****************************************************************
	// latch
	// ****************************************************************
	// set wins over a clear in the same cycle
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			latch_r <= 1'b0;
		end else if (live && option_i[`ABH_OPT_LATCH]) begin
			latch_r <= 1'b1;
		end else if (latch_clr_i || !option_i[`ABH_OPT_LATCH]) begin
			latch_r <= 1'b0;
		end
	end

	assign state = live || latch_r;

	// ****************************************************************
	// outputs
	// ****************************************************************
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			alarm_o <= 1'b0;
			do_o    <= 1'b0;
		end else begin
			alarm_o <= state;
			do_o    <= option_i[`ABH_OPT_INVERT] ? !state : state;
		end
	end

endmodule : abh_alarm_chan

`default_nettype wire

// file: design/abh_hb_det.sv
`timescale 1ns/1ns
`default_nettype none
`include "abh_cfg.svh"

module abh_hb_det #(
	parameter int unsigned ON_CYCLES = `ABH_HB_ON_CYCLES
) (
	input  wire logic                  sys_clk_i,
	input  wire logic                  nrst_i,
	input  wire abh_pkg::abh_out1_type out1_type_i,
	input  wire logic                  out1_on_i,
	input  wire abh_pkg::abh_amp_type  ct_current_i,
	input  wire logic                  ct_valid_i,
	input  wire abh_pkg::abh_amp_type  threshold_i,
	input  wire abh_pkg::abh_amp_type  hysteresis_i,
	output logic                       qualified_o,
	output logic                       alarm_o
);
	import abh_pkg::*;

	logic [25:0]      on_cnt_r;
	abh_hb_state_type state_r;
	logic             onoff;
	logic             ready;
	logic [10:0]      recover;

	// analog outputs give no on/off edge to measure against
	assign onoff   = (out1_type_i == `ABH_OUT1_RELAY) || (out1_type_i == `ABH_OUT1_SSR);
	assign ready   = (on_cnt_r >= 26'(ON_CYCLES));
	assign recover = {1'b0, threshold_i} + {1'b0, hysteresis_i};

	// ****************************************************************
	// on-time qualifier
	// ****************************************************************
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			on_cnt_r <= 26'h0000000;
		end else if (!out1_on_i || !onoff) begin
			on_cnt_r <= 26'h0000000;
		end else if (!ready) begin
			on_cnt_r <= on_cnt_r + 26'h0000001;
		end
	end

	// ****************************************************************
	// detection with hysteresis
	// ****************************************************************
	// while output 1 is off nothing is measured, so the verdict holds
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_r <= HB_OFF;
		end else begin
			case (state_r)
				HB_OFF: begin
					if (onoff) begin
						state_r <= HB_WAIT;
					end
				end
				HB_WAIT, HB_OK: begin
					if (!onoff) begin
						state_r <= HB_OFF;
					end else if (ct_valid_i && ready && ct_current_i <= threshold_i) begin
						state_r <= HB_BREAK;
					end else if (ct_valid_i && ready) begin
						state_r <= HB_OK;
					end
				end
				HB_BREAK: begin
					if (!onoff) begin
						state_r <= HB_OFF;
					end else if (ct_valid_i && ready && {1'b0, ct_current_i} > recover) begin
						state_r <= HB_OK;
					end
				end
				default: state_r <= HB_OFF;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			qualified_o <= 1'b0;
			alarm_o     <= 1'b0;
		end else begin
			qualified_o <= ready && onoff;
			alarm_o     <= (state_r == HB_BREAK);
		end
	end

endmodule : abh_hb_det

`default_nettype wire

// file: design/abh_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "abh_cfg.svh"

module abh_top #(
	parameter int unsigned HB_ON_CYCLES = `ABH_HB_ON_CYCLES
) (
	input  wire logic                 sys_clk_i,
	input  wire logic                 nrst_i,
	// classic wishbone slave
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	// alarm event sources from the alarm type decoder
	input  wire logic [4:0]           alarm_event_i,
	input  wire logic [4:0]           alarm_hold_type_i,
	input  wire logic                 over_range_indication_i,
	input  wire logic                 under_range_indication_i,
	// hold re-arm causes
	input  wire logic                 set_value_change_i,
	input  wire logic [4:0]           alarm_type_code_change_i,
	input  wire logic [4:0]           alarm_threshold_change_i,
	input  wire logic                 standby_cancel_i,
	// heater current
	input  wire logic                 out1_on_i,
	input  wire abh_pkg::abh_amp_type current_transformer_i,
	input  wire logic                 current_transformer_valid_i,
	// results
	output logic      [4:0]           alarm_o,
	output logic      [4:0]           discrete_out_o,
	output logic                      heater_break_o
);
	import abh_pkg::*;

	// ****************************************************************
	// register state
	// ****************************************************************
	abh_opt_type  alarm_option_word_r [0:4];
	abh_amp_type  heater_break_threshold_r;
	abh_amp_type  heater_break_hysteresis_r;
	abh_out1_type out1_type_r;
	abh_amp_type  ct_last_r;
	logic [4:0]   latch_clr_r;
	logic         ack_r;
	logic [31:0]  dat_r;
	logic [31:0]  rd_nxt;
	logic         bus_req;
	logic         wr_stb;
	logic         wr_lo;
	logic         wr_hi;
	abh_amp_type  wr_amp;
	logic [4:0]   alarm_w;
	logic [4:0]   do_w;
	logic         hb_alarm_w;
	logic         hb_qual_w;
	logic         input_error;
	logic [4:0]   rearm;

	// ****************************************************************
	// bus handshake
	// ****************************************************************
	// one wait state: ack one cycle after the strobe, then dropped
	assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
	assign wr_stb  = bus_req && wb_we_i;
	assign wr_lo   = wr_stb && wb_sel_i[0];
	assign wr_hi   = wr_stb && wb_sel_i[1];

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= bus_req;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	// amperes in bits 9:0 above the top of the range are clamped; bits above 9 are dropped
	always_comb begin
		wr_amp = wb_dat_i[9:0];
		if (wr_amp > `ABH_AMP_MAX) begin
			wr_amp = `ABH_AMP_MAX;
		end
	end

	// ****************************************************************
	// option words
	// ****************************************************************
	// every value 0000 to 1111 is legal, so no filtering on write
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < 5; i++) begin
				alarm_option_word_r[i] <= `ABH_OPT_RST;
			end
		end else if (wr_lo) begin
			case (wb_adr_i)
				`ABH_OFF_OPT1: alarm_option_word_r[0] <= wb_dat_i[3:0];
				`ABH_OFF_OPT2: alarm_option_word_r[1] <= wb_dat_i[3:0];
				`ABH_OFF_OPT3: alarm_option_word_r[2] <= wb_dat_i[3:0];
				`ABH_OFF_OPT4: alarm_option_word_r[3] <= wb_dat_i[3:0];
				`ABH_OFF_OPT5: alarm_option_word_r[4] <= wb_dat_i[3:0];
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// heater-break settings
	// ****************************************************************
	// both bytes must be enabled, a half-written current would glitch
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			heater_break_threshold_r <= `ABH_AMP_RST;
		end else if (wr_lo && wr_hi && wb_adr_i == `ABH_OFF_HB_THR) begin
			heater_break_threshold_r <= wr_amp;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			heater_break_hysteresis_r <= `ABH_AMP_RST;
		end else if (wr_lo && wr_hi && wb_adr_i == `ABH_OFF_HB_HYS) begin
			heater_break_hysteresis_r <= wr_amp;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			out1_type_r <= `ABH_OUT1_RST;
		end else if (wr_lo && wb_adr_i == `ABH_OFF_CFG) begin
			out1_type_r <= wb_dat_i[`ABH_CFG_OUT1_MSB:`ABH_CFG_OUT1_LSB];
		end
	end

	// last sampled heater current, for setting the threshold by hand
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ct_last_r <= `ABH_AMP_RST;
		end else if (current_transformer_valid_i) begin
			ct_last_r <= current_transformer_i;
		end
	end

	// ****************************************************************
	// latch clear strobes
	// ****************************************************************
	// write-one pulse, lasts a single cycle
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			latch_clr_r <= 5'h00;
		end else if (wr_lo && wb_adr_i == `ABH_OFF_LATCH_CLR) begin
			latch_clr_r <= wb_dat_i[4:0];
		end else begin
			latch_clr_r <= 5'h00;
		end
	end

	// ****************************************************************
	// read data
	// ****************************************************************
	always_comb begin
		rd_nxt = 32'h00000000;
		case (wb_adr_i)
			`ABH_OFF_OPT1:    rd_nxt[3:0] = alarm_option_word_r[0];
			`ABH_OFF_OPT2:    rd_nxt[3:0] = alarm_option_word_r[1];
			`ABH_OFF_OPT3:    rd_nxt[3:0] = alarm_option_word_r[2];
			`ABH_OFF_OPT4:    rd_nxt[3:0] = alarm_option_word_r[3];
			`ABH_OFF_OPT5:    rd_nxt[3:0] = alarm_option_word_r[4];
			`ABH_OFF_HB_THR:  rd_nxt[9:0] = heater_break_threshold_r;
			`ABH_OFF_HB_HYS:  rd_nxt[9:0] = heater_break_hysteresis_r;
			`ABH_OFF_CFG:     rd_nxt[1:0] = out1_type_r;
			`ABH_OFF_CT_NOW:  rd_nxt[9:0] = ct_last_r;
			`ABH_OFF_STATUS: begin
				rd_nxt[`ABH_ST_ALM_MSB:`ABH_ST_ALM_LSB] = alarm_w;
				rd_nxt[`ABH_ST_DO_MSB:`ABH_ST_DO_LSB]   = do_w;
				rd_nxt[`ABH_ST_HB_ALM]                  = hb_alarm_w;
				rd_nxt[`ABH_ST_HB_QUAL]                 = hb_qual_w;
			end
			default:          rd_nxt = 32'h00000000;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dat_r <= 32'h00000000;
		end else if (bus_req && !wb_we_i) begin
			dat_r <= rd_nxt;
		end
	end

	// ****************************************************************
	// alarm channels
	// ****************************************************************
	// type code zero is left to software when input-error alarming is used
	assign input_error = over_range_indication_i || under_range_indication_i;

	always_comb begin
		for (int i = 0; i < 5; i++) begin
			rearm[i] = set_value_change_i || alarm_type_code_change_i[i]
				|| alarm_threshold_change_i[i] || standby_cancel_i;
		end
	end

	for (genvar g = 0; g < 5; g++) begin : g_chan
		abh_alarm_chan u_chan (
			.sys_clk_i     (sys_clk_i),
			.nrst_i        (nrst_i),
			.option_i      (alarm_option_word_r[g]),
			.event_i       (alarm_event_i[g]),
			.hold_type_i   (alarm_hold_type_i[g]),
			.input_error_i (input_error),
			.rearm_i       (rearm[g]),
			.latch_clr_i   (latch_clr_r[g]),
			.alarm_o       (alarm_w[g]),
			.do_o          (do_w[g])
		);
	end

	// ****************************************************************
	// heater-break detector
	// ****************************************************************
	// under phase-angle firing the current is never a clean on value
	abh_hb_det #(
		.ON_CYCLES (HB_ON_CYCLES)
	) u_hb (
		.sys_clk_i    (sys_clk_i),
		.nrst_i       (nrst_i),
		.out1_type_i  (out1_type_r),
		.out1_on_i    (out1_on_i),
		.ct_current_i (current_transformer_i),
		.ct_valid_i   (current_transformer_valid_i),
		.threshold_i  (heater_break_threshold_r),
		.hysteresis_i (heater_break_hysteresis_r),
		.qualified_o  (hb_qual_w),
		.alarm_o      (hb_alarm_w)
	);

	assign alarm_o        = alarm_w;
	assign discrete_out_o = do_w;
	assign heater_break_o = hb_alarm_w;

endmodule : abh_top

`default_nettype wire

// file: verification/abh_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "abh_cfg.svh"
// ****
// port checks
// ****
module abh_top_assertions #(
	parameter int unsigned HB_ON_CYCLES = 20
) (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic [4:0] alarm_event_i,
	input wire logic [4:0] alarm_hold_type_i,
	input wire logic over_range_indication_i,
	input wire logic under_range_indication_i,
	input wire logic out1_on_i,
	input wire abh_pkg::abh_amp_type current_transformer_i,
	input wire logic current_transformer_valid_i,
	input wire logic [4:0] alarm_o,
	input wire logic [4:0] discrete_out_o,
	input wire logic heater_break_o
);
	import abh_pkg::*;
	logic [4:0] latch_r, inerr_r, inv_r;
	abh_amp_type thr_r, hys_r, wv;
	logic analog_r, wr;
	logic [31:0] on_cnt_r;
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
	assign wv = (wb_dat_i[9:0] > `ABH_AMP_MAX) ? `ABH_AMP_MAX : wb_dat_i[9:0];
	// shadow of the settings, taken at the same edge as the design
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			latch_r <= '0;
			inerr_r <= '0;
			inv_r <= '0;
			thr_r <= '0;
			hys_r <= '0;
			analog_r <= 1'b0;
		end else if (wr) begin
			for (int i = 0; i < 5; i++) begin
				if (wb_adr_i == 8'(4 * i)) begin
					latch_r[i] <= wb_dat_i[0];
					inerr_r[i] <= wb_dat_i[1];
					inv_r[i] <= wb_dat_i[2];
				end
			end
			if (wb_adr_i == `ABH_OFF_HB_THR && wb_sel_i[1]) thr_r <= wv;
			if (wb_adr_i == `ABH_OFF_HB_HYS && wb_sel_i[1]) hys_r <= wv;
			if (wb_adr_i == `ABH_OFF_CFG) analog_r <= wb_dat_i[1];
		end
	end
	// margins of two cycles absorb the design's own counting phase
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) on_cnt_r <= '0;
		else if (!out1_on_i || analog_r) on_cnt_r <= '0;
		else if (on_cnt_r < 32'hFFFF) on_cnt_r <= on_cnt_r + 1;
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	sequence qual_sample;
		current_transformer_valid_i && out1_on_i && !wr && !analog_r
			&& on_cnt_r >= HB_ON_CYCLES + 2;
	endsequence
	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	AST_EVENT: assert property ((|(alarm_event_i & ~alarm_hold_type_i)) |=>
		(alarm_o & $past(alarm_event_i & ~alarm_hold_type_i))
		== $past(alarm_event_i & ~alarm_hold_type_i)) else $error("event lost");
	AST_INERR: assert property (over_range_indication_i || under_range_indication_i
		|=> (alarm_o & $past(inerr_r)) == $past(inerr_r)) else $error("input error lost");
	AST_LATCH: assert property (!wr && !$past(wr) && !$past(wr, 2) |=>
		(alarm_o & $past(alarm_o & latch_r)) == $past(alarm_o & latch_r))
		else $error("latch dropped");
	AST_INVERT: assert property ($stable(inv_r) |->
		discrete_out_o == (alarm_o ^ inv_r)) else $error("terminal polarity");
	AST_HB_SET: assert property (qual_sample ##0 current_transformer_i <= thr_r
		|=> ##1 heater_break_o) else $error("break missed");
	AST_HB_CLR: assert property (qual_sample ##0
		current_transformer_i > {1'b0, thr_r} + hys_r |=> ##1 !heater_break_o)
		else $error("break not cleared");
	AST_HB_EARLY: assert property (on_cnt_r < HB_ON_CYCLES - 2
		&& $past(on_cnt_r) < HB_ON_CYCLES - 2 && !heater_break_o |=> !heater_break_o)
		else $error("early sample used");
	AST_HB_ANALOG: assert property (analog_r && $past(analog_r) && $past(analog_r, 2)
		|-> !heater_break_o)
		else $error("break on analog output");
endmodule : abh_top_assertions

bind abh_top abh_top_assertions #(.HB_ON_CYCLES(HB_ON_CYCLES)) abh_top_assertions_inst (
	.sys_clk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
	.wb_dat_i, .wb_ack_o, .alarm_event_i, .alarm_hold_type_i,
	.over_range_indication_i, .under_range_indication_i, .out1_on_i,
	.current_transformer_i, .current_transformer_valid_i, .alarm_o,
	.discrete_out_o, .heater_break_o);

`default_nettype wire

// file: verification/abh_ct_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// current transformer
// ****
module abh_ct_model #(
	parameter int unsigned PERIOD = 4
) (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic heater_on_i,
	input wire abh_pkg::abh_amp_type load_amps_i,
	output abh_pkg::abh_amp_type ct_amps_o,
	output logic ct_valid_o
);
	import abh_pkg::*;
	logic [7:0] phase_r;
	// on/off drive only, phase-angle firing is not modelled
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			phase_r <= '0;
			ct_valid_o <= 1'b0;
			ct_amps_o <= '0;
		end else begin
			phase_r <= (phase_r == 8'(PERIOD - 1)) ? 8'h00 : phase_r + 8'h01;
			ct_valid_o <= (phase_r == 8'h00);
			// inverted every cycle between samples, so a late read sees garbage
			if (phase_r == 8'h00) ct_amps_o <= heater_on_i ? load_amps_i : '0;
			else ct_amps_o <= ~ct_amps_o;
		end
	end
endmodule : abh_ct_model

`default_nettype wire

// file: verification/abh_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "abh_cfg.svh"
// ****
// bench
// ****
module abh_top_bench;
	import abh_pkg::*;
	localparam int unsigned ON = 20;
	logic sys_clk_i = 0, nrst_i = 0, cyc = 0, stb = 0, we = 0, ack;
	logic [7:0] adr = '0;
	logic [3:0] sel = '0;
	logic [31:0] wdat = '0, rdat, q;
	logic [4:0] ev = '0, hold = '0, tchg = '0, achg = '0, alm, dout;
	logic ovr = 0, und = 0, svchg = 0, sbc = 0, on = 0, hb, ctv;
	abh_amp_type amps = '0, ct;
	int failures = 0, checks_done = 0, cycles = 0;

	abh_top #(.HB_ON_CYCLES(ON)) abh_top_inst (
		.sys_clk_i, .nrst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .alarm_event_i(ev), .alarm_hold_type_i(hold),
		.over_range_indication_i(ovr), .under_range_indication_i(und),
		.set_value_change_i(svchg), .alarm_type_code_change_i(tchg),
		.alarm_threshold_change_i(achg), .standby_cancel_i(sbc), .out1_on_i(on),
		.current_transformer_i(ct), .current_transformer_valid_i(ctv),
		.alarm_o(alm), .discrete_out_o(dout), .heater_break_o(hb));
	abh_ct_model abh_ct_model_inst (.sys_clk_i, .nrst_i, .heater_on_i(on),
		.load_amps_i(amps), .ct_amps_o(ct), .ct_valid_o(ctv));

	always #4 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			report_and_stop();
		end
	end

	task automatic report_and_stop;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask : tick
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// request held until ack is seen at a rising edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		@(posedge sys_clk_i);
		while (ack !== 1'b1) @(posedge sys_clk_i);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge sys_clk_i);
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 4'hF);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0, 4'hF);
		check(q, e);
	endtask : rd_chk

	task automatic reg_test;
		for (int i = 0; i < 8; i++) rd_chk(8'(4 * i), 32'h0);
		for (int i = 0; i < 5; i++) begin
			wr(8'(4 * i), 32'hFFFFFFFF);
			rd_chk(8'(4 * i), 32'hF);
			wr(8'(4 * i), 32'h0);
		end
		wb(1'b1, `ABH_OFF_OPT1, 32'hF, 4'h0);
		rd_chk(`ABH_OFF_OPT1, 32'h0);
		rd_chk(8'h3C, 32'h0);
		wr(`ABH_OFF_HB_THR, 32'h7FF);
		rd_chk(`ABH_OFF_HB_THR, 32'h3E8);
		wr(`ABH_OFF_HB_HYS, 32'h3E8);
		rd_chk(`ABH_OFF_HB_HYS, 32'h3E8);
	endtask : reg_test
	task automatic latch_test;
		wr(`ABH_OFF_OPT1, 32'h1);
		ev <= 5'h03;
		tick(2);
		ev <= 5'h00;
		tick(3);
		check(alm, 5'h01);
		wr(`ABH_OFF_LATCH_CLR, 32'h1);
		tick(2);
		check(alm, 5'h00);
	endtask : latch_test
	task automatic inerr_test;
		// channel two keeps no event of its own, as with type code zero
		wr(`ABH_OFF_OPT2, 32'h2);
		for (int i = 0; i < 2; i++) begin
			{ovr, und} <= i ? 2'b01 : 2'b10;
			tick(3);
			check(alm, 5'h02);
			{ovr, und} <= 2'b00;
			tick(3);
			check(alm, 5'h00);
		end
	endtask : inerr_test
	task automatic invert_test;
		wr(`ABH_OFF_OPT3, 32'h4);
		tick(2);
		check(dout, 5'h04);
		ev[2] <= 1'b1;
		tick(3);
		check({alm, dout}, {5'h04, 5'h00});
		ev[2] <= 1'b0;
		tick(3);
		check(dout, 5'h04);
	endtask : invert_test
	task automatic hold_test;
		// power cycle with the event already present arms the hold
		hold[4] <= 1'b1;
		ev[4] <= 1'b1;
		nrst_i <= 1'b0;
		tick(2);
		nrst_i <= 1'b1;
		tick(1);
		wr(`ABH_OFF_OPT5, 32'h8);
		tick(3);
		check(alm[4], 1'b0);
		for (int k = 0; k < 5; k++) begin
			ev[4] <= 1'b0;
			tick(2);
			ev[4] <= 1'b1;
			tick(3);
			check(alm[4], 1'b1);
			if (k == 4) wr(`ABH_OFF_OPT5, 32'h0);
			case (k)
				0, 4: svchg <= 1'b1;
				1: tchg[4] <= 1'b1;
				2: achg[4] <= 1'b1;
				default: sbc <= 1'b1;
			endcase
			tick(1);
			{svchg, tchg, achg, sbc} <= '0;
			tick(3);
			check(alm[4], k == 4);
		end
		ev[4] <= 1'b0;
		hold[4] <= 1'b0;
	endtask : hold_test
	task automatic hb_test;
		// 5.0 A trip, near 77 percent of a 6.5 A heater
		wr(`ABH_OFF_HB_THR, 32'h32);
		wr(`ABH_OFF_HB_HYS, 32'h14);
		amps <= 10'h028;
		on <= 1'b1;
		tick(ON - 4);
		check(hb, 1'b0);
		tick(12);
		check(hb, 1'b1);
		amps <= 10'h03C;
		tick(10);
		check(hb, 1'b1);
		amps <= 10'h047;
		tick(10);
		check(hb, 1'b0);
		amps <= 10'h032;
		tick(10);
		check(hb, 1'b1);
		rd_chk(`ABH_OFF_STATUS, 32'hC00);
		rd_chk(`ABH_OFF_CT_NOW, 32'h32);
		for (int t = 2; t < 4; t++) begin
			// back to relay drive, so each analog type has a break to drop
			wr(`ABH_OFF_CFG, 32'h0);
			tick(ON + 8);
			check(hb, 1'b1);
			wr(`ABH_OFF_CFG, 32'(t));
			tick(3);
			check(hb, 1'b0);
		end
		wr(`ABH_OFF_CFG, 32'h0);
	endtask : hb_test

	initial begin
		tick(16);
		nrst_i <= 1'b1;
		tick(1);
		reg_test();
		latch_test();
		inerr_test();
		invert_test();
		hold_test();
		hb_test();
		report_and_stop();
	end
endmodule : abh_top_bench

`default_nettype wire
